// [iva_core.sv]
// Interrupt vector arbiter: acknowledge, vector select, trap flag, APB
//
// What this block does
// R1 - Vector select yields an even offset E0..FE from the top active source.
// R2 - Offset is taken from sources as seen in the first vector select cycle.
// R3 - A pending trap always yields offset FE.
// R4 - External pin interrupt yields FA when no trap is pending.
// R5 - Lower ranks: F8, F6, F4, F2, EA, E8, E2 in that order.
// R6 - With nothing active the default slot E0 is chosen.
// R7 - The offset replaces only the low byte of the program counter.
// R8 - The high byte stays, so the table lies in the current page.
// R9 - The stored vector is fetched and loaded into the program counter.
// R10 - Table sits in the page of the next address after vector select.
// R11 - The trap pending flag has no register address at all.
// R12 - Reset clears the trap pending flag.
// R13 - A trap sets the trap pending flag.
// R14 - The pending-clear instruction clears the trap pending flag unless a trap executes in the same cycle.
// R15 - While the trap flag is set no maskable interrupt is taken.
// R16 - Software should identify sources by vector select, not by polling.
// R17 - Maskable interrupts taken only at instruction start with both enables.
// R18 - Acknowledge clears global enable, pushes address, jumps 00FF in seven cycles.
// R19 - Table entry is 15 bits, high byte at the even address.
// R20 - Return from interrupt sets global enable and pops the saved address.
// R21 - Reserved table slots are never produced.
// R22 - Source is active when enabled and pending; trap when its flag is set.
`timescale 1ns/1ps
`default_nettype none
`include "iva_params.svh"

module iva_core
  import iva_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Core sequencer
  input  wire logic              instr_start,
  input  wire logic              vis_exec,
  input  wire logic              trap_exec,
  input  wire logic              pend_clear_exec,
  input  wire logic              return_from_irq_exec,
  input  wire logic [14:0]       pc_next,
  input  wire logic [7:0]        src_event,
  output logic                   busy,
  output logic                   pc_load,
  output logic      [14:0]       pc_value,
  output logic                   push_req,
  output logic      [14:0]       push_addr,
  output logic                   pop_req,
  input  wire logic [14:0]       pop_data,
  // Program memory, data one cycle after the read strobe
  output logic                   pmem_rd,
  output logic      [14:0]       pmem_addr,
  input  wire logic [7:0]        pmem_data
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (ADDR_W < 4) begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  iva_state_t  state;
  iva_state_t  next_state;
  logic [2:0]  cnt;
  logic [7:0]  irq_en;
  logic [7:0]  irq_pend;
  logic        global_irq_enable;
  logic        trap_pending_flag;
  logic [7:0]  vis_off;
  logic [7:0]  vec_hi;
  logic [7:0]  active;
  logic [7:0]  rank_slot;
  logic        idle;
  logic        vis_go;
  logic        trap_go;
  logic        return_from_irq_go;
  logic        mask_take;
  logic        apb_acc;
  logic        apb_wr;
  logic [7:0]  pend_clr;

  // Address match helper for the register decode
  function automatic logic reg_at(input logic [ADDR_W-1:0] a,
                                  input logic [11:0]       off);
    reg_at = (a == ADDR_W'(off));
  endfunction : reg_at

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = reg_at(a, `IVA_ADDR_CTRL) | reg_at(a, `IVA_ADDR_PEND) |
              reg_at(a, `IVA_ADDR_STAT);
  endfunction : reg_hit

  // ----------------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------------
  assign active = irq_en & irq_pend;                     // [R22]

  iva_rank u_rank (
    .trap_active (trap_pending_flag),                    // [R22]
    .active      (active),
    .slot        (rank_slot)
  );

  assign idle    = (state == IVA_IDLE);
  assign trap_go = idle & trap_exec;
  assign vis_go  = idle & vis_exec & ~trap_exec;
  assign return_from_irq_go = idle & return_from_irq_exec & ~trap_exec & ~vis_exec;
  // Only at an instruction boundary, never while a trap is outstanding
  assign mask_take = idle & instr_start & ~trap_exec & ~vis_exec &
                     ~return_from_irq_exec & global_irq_enable & ~trap_pending_flag &
                     (|active);                          // [R15] [R17]

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      IVA_IDLE: begin
        if (trap_go || mask_take) begin
          next_state = IVA_ACK;
        end else if (vis_go) begin
          next_state = IVA_VHI;
        end else if (return_from_irq_go) begin
          next_state = IVA_RET;
        end
      end
      IVA_ACK: begin
        if (cnt == `IVA_ACK_CYCLES - 3'd1) begin
          next_state = IVA_IDLE;
        end
      end
      IVA_VHI: next_state = IVA_VLO;
      IVA_VLO: next_state = IVA_VLD;
      IVA_VLD: next_state = IVA_IDLE;
      IVA_RET: begin
        if (cnt == 3'd1) begin
          next_state = IVA_IDLE;
        end
      end
      default: next_state = IVA_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= IVA_IDLE;
      busy  <= 1'b0;
      cnt   <= 3'd0;
    end else begin
      state <= next_state;
      busy  <= (next_state != IVA_IDLE);
      if (next_state != state) begin
        cnt <= 3'd0;
      end else if (!idle) begin
        cnt <= cnt + 3'd1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Program counter, stack and fetch strobes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_load   <= 1'b0;
      pc_value  <= 15'h0000;
      push_req  <= 1'b0;
      push_addr <= 15'h0000;
      pop_req   <= 1'b0;
      pmem_rd   <= 1'b0;
      pmem_addr <= 15'h0000;
      vis_off   <= `IVA_OFF_RESET;
      vec_hi    <= 8'h00;
    end else begin
      pc_load  <= 1'b0;
      push_req <= 1'b0;
      pop_req  <= 1'b0;
      case (state)
        IVA_IDLE: begin
          if (trap_go || mask_take) begin
            push_req  <= 1'b1;                           // [R18]
            push_addr <= pc_next;
          end else if (vis_go) begin
            // Slot is frozen here; later source changes cannot move it
            vis_off   <= rank_slot;                      // [R2] [R1]
            pmem_rd   <= 1'b1;
            // Next address after the instruction picks the page, which
            // also rolls the table into the next page at a page end
            pmem_addr <= {pc_next[14:8], rank_slot};     // [R7] [R8] [R10]
          end else if (return_from_irq_go) begin
            pop_req <= 1'b1;                             // [R20]
          end
        end
        IVA_ACK: begin
          // Load lands on the seventh cycle after the acknowledge edge
          if (cnt == `IVA_ACK_CYCLES - 3'd2) begin
            pc_load  <= 1'b1;                            // [R18]
            pc_value <= `IVA_JUMP_ADDR;
          end
        end
        IVA_VHI: begin
          pmem_addr <= pmem_addr | {7'h00, `IVA_LO_BYTE}; // [R19]
        end
        IVA_VLO: begin
          vec_hi  <= pmem_data;                          // [R19]
          pmem_rd <= 1'b0;
        end
        IVA_VLD: begin
          pc_load  <= 1'b1;                              // [R9]
          pc_value <= {vec_hi[6:0], pmem_data};          // [R9] [R19]
        end
        IVA_RET: begin
          // Stack answers one cycle after the pop strobe
          if (cnt == 3'd1) begin
            pc_load  <= 1'b1;                            // [R20]
            pc_value <= pop_data;
          end
        end
        default: begin
          pmem_rd <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Trap pending flag, internal only, never on the bus
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trap_pending_flag <= 1'b0;                         // [R12]
    end else if (trap_exec) begin
      trap_pending_flag <= 1'b1;                         // [R13]
    end else if (pend_clear_exec) begin
      trap_pending_flag <= 1'b0;                         // [R14]
    end
  end

  // ----------------------------------------------------------------------
  // Global enable: acknowledge clears, return sets, software writes last
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      global_irq_enable <= 1'b0;
    end else if (mask_take) begin
      global_irq_enable <= 1'b0;                                       // [R18]
    end else if (return_from_irq_go) begin
      global_irq_enable <= 1'b1;                                       // [R20]
    end else if (apb_wr && reg_at(paddr, `IVA_ADDR_CTRL)) begin
      global_irq_enable <= pwdata[`IVA_GIE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Source enables and pending bits
  // ----------------------------------------------------------------------
  assign apb_acc  = psel & penable & pready;
  assign apb_wr   = apb_acc & pwrite;
  assign pend_clr = (apb_wr && reg_at(paddr, `IVA_ADDR_PEND)) ?
                    pwdata[7:0] : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en <= `IVA_EN_RESET;
    end else if (apb_wr && reg_at(paddr, `IVA_ADDR_CTRL)) begin
      irq_en <= pwdata[7:0];
    end
  end

  // A source event in the clearing cycle survives the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_pend <= `IVA_PEND_RESET;
    end else begin
      irq_pend <= (irq_pend & ~pend_clr) | src_event;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave: one wait state, error on unmapped addresses
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~reg_hit(paddr);
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite) begin
        // Trap flag deliberately absent from every readable word
        if (reg_at(paddr, `IVA_ADDR_CTRL)) begin
          prdata <= {23'h000000, global_irq_enable, irq_en};           // [R11]
        end else if (reg_at(paddr, `IVA_ADDR_PEND)) begin
          prdata <= {24'h000000, irq_pend};
        end else if (reg_at(paddr, `IVA_ADDR_STAT)) begin
          prdata <= {21'h000000, state == IVA_RET,
                     state == IVA_VHI || state == IVA_VLO ||
                     state == IVA_VLD,
                     state == IVA_ACK, vis_off};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence vis_fetch_s;
    ##1 (pmem_rd && pmem_addr[0] == 1'b0) ##1 (pmem_rd && pmem_addr[0]);
  endsequence

  sequence vis_load_s;
    ##2 (pc_load && pc_value[7:0] == $past(pmem_data));
  endsequence

  sequence ack_run_s;
    ##1 (busy && !global_irq_enable && push_req) ##1 (busy && !pc_load)[*5]
    ##1 (busy && pc_load && pc_value == `IVA_JUMP_ADDR);
  endsequence

  vis_addr_a: assert property (vis_go |=>
    pmem_addr == {$past(pc_next[14:8]), $past(rank_slot)})    // [R7] [R8] [R10]
    else $error("vector table address wrong");

  vis_even_a: assert property (vis_go |=>
    pmem_addr[7:5] == 3'b111 && pmem_addr[0] == 1'b0)         // [R1]
    else $error("vector offset out of range");

  vis_frozen_a: assert property (vis_go |=>
    (vis_off == $past(rank_slot)) ##1 (vis_off == $past(rank_slot, 2)) ##1
    (vis_off == $past(rank_slot, 3)))                         // [R2]
    else $error("offset changed after first cycle");

  trap_slot_a: assert property (vis_go && trap_pending_flag |=>
    pmem_addr[7:0] == `IVA_SLOT_TRAP)                         // [R3]
    else $error("trap did not win arbitration");

  ext_slot_a: assert property (vis_go && !trap_pending_flag &&
    active[0] |=> pmem_addr[7:0] == `IVA_SLOT_EXT)            // [R4]
    else $error("external slot wrong");

  dflt_slot_a: assert property (vis_go && !trap_pending_flag &&
    active == 8'h00 |=> pmem_addr[7:0] == `IVA_SLOT_DFLT)     // [R6]
    else $error("default slot wrong");

  no_resv_a: assert property (vis_go |-> !(rank_slot inside
    {8'hFC, 8'hF0, 8'hEE, 8'hEC, 8'hE6, 8'hE4}))              // [R21]
    else $error("reserved slot produced");

  vis_vector_a: assert property (vis_go |-> vis_fetch_s ##0
    vis_load_s)                                               // [R9] [R19]
    else $error("vector not loaded");

  trap_set_a: assert property (trap_exec |=> trap_pending_flag) // [R13]
    else $error("trap flag not set");

  trap_clr_a: assert property (pend_clear_exec && !trap_exec |=>
    !trap_pending_flag)                                       // [R14]
    else $error("trap flag not cleared");

  mask_block_a: assert property ($fell(global_irq_enable) && !$past(apb_wr) |->
    $past(!trap_pending_flag && instr_start))                 // [R15] [R17]
    else $error("maskable taken while blocked");

  ack_seq_a: assert property (mask_take |-> ack_run_s)        // [R18]
    else $error("acknowledge sequence wrong");

  return_from_irq_seq_a: assert property (return_from_irq_go |=> global_irq_enable && pop_req ##1
    (pc_load == 1'b0) ##1 (pc_load && pc_value == $past(pop_data))) // [R20]
    else $error("return sequence wrong");

endmodule : iva_core
`default_nettype wire

// [iva_params.svh]
// Constants for the interrupt vector arbiter: offsets, slots and counts
`ifndef IVA_PARAMS_SVH
`define IVA_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define IVA_ADDR_CTRL  12'h000
`define IVA_ADDR_PEND  12'h004
`define IVA_ADDR_STAT  12'h008

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define IVA_GIE_BIT    8
`define IVA_STAT_ACK   8
`define IVA_STAT_VIS   9
`define IVA_STAT_RET   10
`define IVA_EN_RESET   8'h00
`define IVA_PEND_RESET 8'h00
`define IVA_OFF_RESET  8'hE0

// ----------------------------------------------------------------------
// Vector table slots, highest rank first
// ----------------------------------------------------------------------
`define IVA_SLOT_TRAP  8'hFE
`define IVA_SLOT_EXT   8'hFA
`define IVA_SLOT_IDLE  8'hF8
`define IVA_SLOT_T1A   8'hF6
`define IVA_SLOT_T1B   8'hF4
`define IVA_SLOT_SER   8'hF2
`define IVA_SLOT_T2A   8'hEA
`define IVA_SLOT_T2B   8'hE8
`define IVA_SLOT_WAKE  8'hE2
`define IVA_SLOT_DFLT  8'hE0

// ----------------------------------------------------------------------
// Sequencing
// ----------------------------------------------------------------------
`define IVA_ACK_CYCLES 3'd7
`define IVA_JUMP_ADDR  15'h00FF
`define IVA_LO_BYTE    8'h01

`endif

// [iva_pkg.sv]
// Types shared by the interrupt vector arbiter modules
package iva_pkg;

  // ----------------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    IVA_IDLE = 6'b000001,
    IVA_ACK  = 6'b000010,
    IVA_VHI  = 6'b000100,
    IVA_VLO  = 6'b001000,
    IVA_VLD  = 6'b010000,
    IVA_RET  = 6'b100000
  } iva_state_t;

endpackage : iva_pkg

// [iva_rank.sv]
// Priority ranking of active interrupt sources into a vector table slot
`timescale 1ns/1ps
`default_nettype none
`include "iva_params.svh"

module iva_rank (
  input  wire logic       trap_active,
  input  wire logic [7:0] active,
  output logic      [7:0] slot
);

  // ----------------------------------------------------------------------
  // Fixed ranking; reserved slots are never produced
  // ----------------------------------------------------------------------
  always_comb begin
    if (trap_active) begin
      slot = `IVA_SLOT_TRAP;                 // [R3]
    end else if (active[0]) begin
      slot = `IVA_SLOT_EXT;                  // [R4]
    end else if (active[1]) begin
      slot = `IVA_SLOT_IDLE;                 // [R5]
    end else if (active[2]) begin
      slot = `IVA_SLOT_T1A;                  // [R5]
    end else if (active[3]) begin
      slot = `IVA_SLOT_T1B;                  // [R5]
    end else if (active[4]) begin
      slot = `IVA_SLOT_SER;                  // [R5] [R21]
    end else if (active[5]) begin
      slot = `IVA_SLOT_T2A;                  // [R5]
    end else if (active[6]) begin
      slot = `IVA_SLOT_T2B;                  // [R5] [R21]
    end else if (active[7]) begin
      slot = `IVA_SLOT_WAKE;                 // [R5]
    end else begin
      slot = `IVA_SLOT_DFLT;                 // [R6]
    end
  end

endmodule : iva_rank
`default_nettype wire

// [iva_core_model.sv]
// Core-side partner: program memory fetch path and return stack
`timescale 1ns/1ps
`default_nettype none

module iva_core_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        pmem_rd,
  input  wire logic [14:0] pmem_addr,
  output logic      [7:0]  pmem_data,
  input  wire logic        push_req,
  input  wire logic [14:0] push_addr,
  input  wire logic        pop_req,
  output logic      [14:0] pop_data
);
  // ----------------------------------------------------------------------
  // Program memory
  // ----------------------------------------------------------------------
  logic [14:0] stack [0:7];
  logic [2:0]  sp;

  // Even byte is the high byte with a stray top bit set, so a design
  // that keeps bit 7 of it shows up as a wrong target
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pmem_data <= 8'h00;
    end else if (pmem_rd) begin
      pmem_data <= pmem_addr[0] ? (pmem_addr[7:0] ^ 8'hA5)
                                : {1'b1, pmem_addr[14:8]};
    end else begin
      pmem_data <= ~pmem_data; // Released bus toggles, stale bytes never look valid
    end
  end

  // ----------------------------------------------------------------------
  // Return stack, eight deep; wraps silently on overflow
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp       <= 3'd0;
      pop_data <= 15'h0000;
    end else if (push_req) begin
      stack[sp] <= push_addr;
      sp        <= sp + 3'd1;
    end else if (pop_req) begin
      pop_data <= stack[sp - 3'd1];
      sp       <= sp - 3'd1;
    end else begin
      pop_data <= ~pop_data;
    end
  end
endmodule : iva_core_model

`default_nettype wire

// [interrupt_vector_arbiter_tb.sv]
// Self-checking testbench for the interrupt vector arbiter
`timescale 1ns/1ps
`default_nettype none
`include "iva_params.svh"

module interrupt_vector_arbiter_tb;
  // ----------------------------------------------------------------------
  // Signals and constants
  // ----------------------------------------------------------------------
  localparam logic [4:0] START = 5'h10;
  localparam logic [4:0] VECTOR_SELECT_INSTRUCTION   = 5'h08;
  localparam logic [4:0] TRAP  = 5'h04;
  localparam logic [4:0] CLR   = 5'h02;
  localparam logic [4:0] RET   = 5'h01;
  localparam logic [7:0] SLOT [8] = '{8'hFA, 8'hF8, 8'hF6, 8'hF4, 8'hF2, 8'hEA, 8'hE8, 8'hE2};

  logic        clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic        instr_start, vis_exec, trap_exec, pend_clear_exec, return_from_irq_exec;
  logic        busy, pc_load, push_req, pop_req, pmem_rd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, rnd;
  logic [14:0] pc_next, pc_value, push_addr, pop_data, pmem_addr, pushed, pcv;
  logic [7:0]  src_event, pmem_data, m;
  int          bad_count, cmp_count, cyc, nb;

  iva_core i_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_start(instr_start), .vis_exec(vis_exec), .trap_exec(trap_exec),
    .pend_clear_exec(pend_clear_exec), .return_from_irq_exec(return_from_irq_exec), .pc_next(pc_next),
    .src_event(src_event), .busy(busy), .pc_load(pc_load), .pc_value(pc_value),
    .push_req(push_req), .push_addr(push_addr), .pop_req(pop_req), .pop_data(pop_data),
    .pmem_rd(pmem_rd), .pmem_addr(pmem_addr), .pmem_data(pmem_data)
  );

  iva_core_model i_model (
    .clk(clk), .rst(rst), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
    .push_req(push_req), .push_addr(push_addr), .pop_req(pop_req), .pop_data(pop_data)
  );

  always #5 clk = ~clk;

  // ----------------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = x[0] ? ((x >> 1) ^ 32'hA3000000) : (x >> 1);
  endfunction : lfsr

  function automatic logic [7:0] slot_of(input logic tr, input logic [7:0] act);
    slot_of = 8'hE0;
    for (int i = 7; i >= 0; i--) if (act[i]) slot_of = SLOT[i];
    if (tr) slot_of = 8'hFE;
  endfunction : slot_of

  // Target that the partner memory holds for a slot in a page
  function automatic logic [31:0] vec(input logic [6:0] page, input logic [7:0] slot);
    vec = {17'h0, page, (slot | 8'h01) ^ 8'hA5};
  endfunction : vec

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  task automatic ev(input logic [7:0] mask);
    src_event <= mask;
    @(posedge clk);
    src_event <= 8'h00;
    @(posedge clk);
  endtask : ev

  // One core pulse, then count cycles with busy high over a quiet window
  task automatic pulse(input logic [4:0] v);
    {instr_start, vis_exec, trap_exec, pend_clear_exec, return_from_irq_exec} <= v;
    @(posedge clk);
    {instr_start, vis_exec, trap_exec, pend_clear_exec, return_from_irq_exec} <= 5'h00;
    nb = 0;
    repeat (10) begin
      @(posedge clk);
      if (busy !== 1'b0) nb++;
    end
  endtask : pulse

  // One core pulse, events in the cycle after it, wait for the program counter load
  task automatic run(input logic [4:0] v, input logic [7:0] late);
    int n;
    {instr_start, vis_exec, trap_exec, pend_clear_exec, return_from_irq_exec} <= v;
    @(posedge clk);
    {instr_start, vis_exec, trap_exec, pend_clear_exec, return_from_irq_exec} <= 5'h00;
    src_event <= late;
    n = 0;
    do begin
      @(posedge clk);
      src_event <= 8'h00;
      n++;
      if (push_req === 1'b1) pushed = push_addr;
    end while (pc_load !== 1'b1 && n < 16);
    pcv = pc_value;
    cyc = n;
    if (pc_load !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
    @(posedge clk);
  endtask : run

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {clk, psel, penable, pwrite, instr_start, vis_exec, trap_exec} = 7'h00;
    {pend_clear_exec, return_from_irq_exec, paddr, pwdata, pc_next, src_event} = '0;
    {bad_count, cmp_count} = '0;
    rst = 1'b1;
    rnd = 32'h77DDD816;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`IVA_ADDR_CTRL, 32'h0);
    rd(`IVA_ADDR_PEND, 32'h0);
    rd(`IVA_ADDR_STAT, 32'h0E0);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // Nothing active; a source arriving after the first cycle must not count
    apb(1'b1, `IVA_ADDR_CTRL, 32'h0FF);
    pc_next <= 15'h0150;
    run(VECTOR_SELECT_INSTRUCTION, 8'h01);
    chk(pcv, vec(7'h01, 8'hE0));
    chk(cyc, 32'd4);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      apb(1'b1, `IVA_ADDR_PEND, 32'hFF);
      ev(8'h01 << i | (rnd[7:0] & ~((8'h02 << i) - 8'h01)));
      run(VECTOR_SELECT_INSTRUCTION, 8'h00);
      chk(pcv, vec(7'h01, SLOT[i]));
    end
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      m = rnd[7:0];
      apb(1'b1, `IVA_ADDR_PEND, 32'hFF);
      ev(m);
      apb(1'b1, `IVA_ADDR_CTRL, {24'h0, rnd[15:8]});
      pc_next <= (k == 0) ? 15'h0200 : rnd[30:16];
      rd(`IVA_ADDR_PEND, {24'h0, m});
      run(VECTOR_SELECT_INSTRUCTION, 8'h00);
      chk(pcv, vec(k == 0 ? 7'h02 : rnd[30:24], slot_of(1'b0, m & rnd[15:8])));
      rd(`IVA_ADDR_STAT, {24'h0, slot_of(1'b0, m & rnd[15:8])});
    end
    // Acknowledge only with both enables at an instruction start
    apb(1'b1, `IVA_ADDR_PEND, 32'hFF);
    apb(1'b1, `IVA_ADDR_CTRL, 32'h004);
    ev(8'h04);
    pulse(START);
    chk(nb, 32'd0);
    apb(1'b1, `IVA_ADDR_CTRL, 32'h104);
    pc_next <= 15'h1234;
    run(START, 8'h00);
    chk(pcv, 32'h00FF);
    chk(cyc, 32'd7);
    chk(pushed, 32'h1234);
    rd(`IVA_ADDR_CTRL, 32'h004);
    pc_next <= 15'h0100;
    run(VECTOR_SELECT_INSTRUCTION, 8'h00);
    chk(pcv, vec(7'h01, 8'hF6));
    run(RET, 8'h00);
    chk(pcv, 32'h1234);
    chk(cyc, 32'd3);
    rd(`IVA_ADDR_CTRL, 32'h104);
    // Trap beats the external source and locks out acknowledgement
    apb(1'b1, `IVA_ADDR_PEND, 32'hFF);
    apb(1'b1, `IVA_ADDR_CTRL, 32'h101);
    ev(8'h01);
    pc_next <= 15'h0456;
    run(TRAP, 8'h00);
    chk(pushed, 32'h0456);
    rd(`IVA_ADDR_CTRL, 32'h101);
    run(VECTOR_SELECT_INSTRUCTION, 8'h00);
    chk(pcv, vec(7'h04, 8'hFE));
    pulse(START);
    chk(nb, 32'd0);
    pulse(CLR);
    run(VECTOR_SELECT_INSTRUCTION, 8'h00);
    chk(pcv, vec(7'h04, 8'hFA));
    run(TRAP, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    run(VECTOR_SELECT_INSTRUCTION, 8'h00);
    chk(pcv, vec(7'h04, 8'hE0));
    print_verdict();
  end
endmodule : interrupt_vector_arbiter_tb

`default_nettype wire
